// file: src/line_if_pkg.sv
// Constants shared by the line-interface control and status block.
// Assumes an 8-bit control port with byte-wide registers at fixed addresses.
package line_if_pkg;

	// ==========================================
	// Register addresses
	localparam logic [7:0] ADDR_RX_LEVEL = 8'h11;
	localparam logic [7:0] ADDR_FAULT_STATUS = 8'h14;
	localparam logic [7:0] ADDR_FAULT_MASK = 8'h15;
	localparam logic [7:0] ADDR_LINE_CTRL2 = 8'h31;
	localparam logic [7:0] ADDR_LINE_CTRL3 = 8'h32;
	localparam logic [7:0] ADDR_LINE_CTRL4 = 8'h33;

	// ==========================================
	// Reset values and writable-bit masks
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] CTRL2_WR_MASK = 8'hFB;
	localparam logic [7:0] CTRL3_WR_MASK = 8'hD9;
	localparam logic [7:0] CTRL4_WR_MASK = 8'hFF;
	localparam logic [7:0] FAULT_BITS_MASK = 8'h16;

	// ==========================================
	// Field positions
	localparam int SEND_ALARM_BIT = 4;
	localparam int INSERT_BPV_BIT = 5;
	localparam int LINE_RESET_BIT = 6;
	localparam int JCLK_HI_BIT = 7;
	localparam int JCLK_LO_BIT = 3;
	localparam int ALT_PATTERN_BIT = 0;
	localparam int GAIN_LSB = 3;
	localparam int CMI_INVERT_BIT = 6;
	localparam int CMI_ENABLE_BIT = 7;
	localparam int RX_TERM_LSB = 0;
	localparam int TX_TERM_LSB = 3;
	localparam int PRESCALE_LSB = 6;
	localparam int OPEN_FLAG_BIT = 1;
	localparam int CLIMIT_FLAG_BIT = 2;
	localparam int JNEAR_FLAG_BIT = 4;

	// ==========================================
	// Termination codes and run length
	localparam logic [2:0] TERM_75 = 3'h1;
	localparam logic [2:0] TERM_100 = 3'h2;
	localparam logic [2:0] TERM_120 = 3'h3;
	localparam logic [2:0] TERM_110 = 3'h4;
	localparam logic [1:0] ONES_BEFORE_BPV = 2'h2;
	localparam logic [1:0] ONES_RUN_MAX = 2'h3;

	typedef enum logic {BPV_IDLE, BPV_ARMED} bpv_state_e;

endpackage : line_if_pkg

// file: src/pin_sync.sv
// Three-stage synchroniser for pin inputs with agreement filter.
// Assumes inputs are asynchronous to clock; output changes once stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] stable_out
);
	logic [WIDTH-1:0] s1_r, s2_r, s3_r, out_r;
	logic [WIDTH-1:0] out_nxt;

	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : out_r[i];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			out_r <= '0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			out_r <= out_nxt;
		end
	end

	assign stable_out = out_r;
endmodule : pin_sync

// file: src/line_interface_control_status.sv
// Line-interface control and status registers with transmit pattern logic.
// Assumes a byte-wide control port on clock and line bits presented one per tx_bit_valid.
//
// Notes on behaviour
// - With alternating bit clear, alarm bit zero sends unframed all ones.
// - Rising insert bit injects exactly one violation.
// - Violation waits for three consecutive ones.
// - Rising reset bit resets recovery, recenters attenuator.
// - Upper clock select enables 12.8-to-2.048 PLL.
// - Lower clock select enables 2.048-to-1.544 PLL.
// - Alternating bit sends continuous one-zero pattern.
// - Two-bit gain code selects receive boost.
// - Invert bit flips coded-mark polarity both ways.
// - Coded-mark enable selects coded-mark line coding.
// - Receive termination code selects 75/100/120/110 ohm.
// - Transmit termination uses the same encoding.
// - Receive level reported live in 2.5 dB bands.
// - Open-circuit flag live, absent in 6312k mode.
// - Current-limit flag live, absent in excluded modes.
// - Jitter limit event latches, clears on read.
// - Masked fault edges, both directions, raise interrupt.
// - Jitter limit interrupt only when mask set.
`timescale 1ns/1ps
module line_interface_control_status (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic tx_bit_valid,
	input wire logic tx_bit,
	output logic tx_line_positive,
	output logic tx_line_negative,
	input wire logic rx_line_positive,
	output logic rx_mark,
	input wire logic [3:0] rx_level_pin,
	input wire logic tx_open_pin,
	input wire logic tx_climit_pin,
	input wire logic jitter_fifo_near_limit,
	input wire logic mode_6312k,
	input wire logic mode_64k,
	output logic recovery_reset,
	output logic pll_12m8_enable,
	output logic pll_2m048_enable,
	output logic [1:0] master_clock_prescale,
	output logic [1:0] monitor_gain,
	output logic coded_mark_enable,
	output logic [3:0] rx_term_enable,
	output logic [3:0] tx_term_enable,
	output logic interrupt_req
);
	// ==========================================
	// Pin synchronisation
	logic [6:0] pins_stable;
	logic rx_sync, open_sync, climit_sync;
	logic [3:0] level_sync;

	pin_sync #(.WIDTH(7)) u_pin_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.pin_in({rx_line_positive, tx_open_pin, tx_climit_pin, rx_level_pin}),
		.stable_out(pins_stable)
	);
	assign {rx_sync, open_sync, climit_sync, level_sync} = pins_stable;

	// ==========================================
	// Registers and status
	logic [7:0] ctrl2_r, ctrl3_r, ctrl4_r, mask_r, rdata_r;
	logic [7:0] ctrl2_nxt, ctrl3_nxt, ctrl4_nxt, mask_nxt, rdata_nxt;
	logic bpv_prev_r, reset_prev_r, recovery_r, jnear_r, open_pend_r, climit_pend_r, irq_r;
	logic open_prev_r, climit_prev_r, rx_mark_r;
	logic jnear_nxt, open_pend_nxt, climit_pend_nxt, irq_nxt, recovery_nxt, rx_mark_nxt;
	logic open_cond, climit_cond, status_read;
	logic [7:0] status_view;
	logic [3:0] rx_term_r, tx_term_r, rx_term_nxt, tx_term_nxt;

	function automatic logic [3:0] term_decode(input logic [2:0] code);
		logic [3:0] onehot;
		onehot = 4'h0;
		case (code)
			line_if_pkg::TERM_75: onehot = 4'h1;
			line_if_pkg::TERM_100: onehot = 4'h2;
			line_if_pkg::TERM_120: onehot = 4'h4;
			line_if_pkg::TERM_110: onehot = 4'h8;
			default: onehot = 4'h0;
		endcase
		return onehot;
	endfunction : term_decode

	// Faults forced quiet in modes where detection is not available
	assign open_cond = open_sync & ~mode_6312k;
	assign climit_cond = climit_sync & ~(ctrl3_r[line_if_pkg::CMI_ENABLE_BIT] | mode_64k | mode_6312k);
	assign status_read = reg_rd && (reg_addr == line_if_pkg::ADDR_FAULT_STATUS);

	always_comb begin
		status_view = 8'h00;
		status_view[line_if_pkg::OPEN_FLAG_BIT] = open_cond;
		status_view[line_if_pkg::CLIMIT_FLAG_BIT] = climit_cond;
		status_view[line_if_pkg::JNEAR_FLAG_BIT] = jnear_r;
	end

	always_comb begin
		ctrl2_nxt = ctrl2_r;
		ctrl3_nxt = ctrl3_r;
		ctrl4_nxt = ctrl4_r;
		mask_nxt = mask_r;
		rdata_nxt = rdata_r;
		if (reg_wr) begin
			case (reg_addr)
				line_if_pkg::ADDR_LINE_CTRL2: ctrl2_nxt = reg_wdata & line_if_pkg::CTRL2_WR_MASK;
				line_if_pkg::ADDR_LINE_CTRL3: ctrl3_nxt = reg_wdata & line_if_pkg::CTRL3_WR_MASK;
				line_if_pkg::ADDR_LINE_CTRL4: ctrl4_nxt = reg_wdata & line_if_pkg::CTRL4_WR_MASK;
				line_if_pkg::ADDR_FAULT_MASK: mask_nxt = reg_wdata & line_if_pkg::FAULT_BITS_MASK;
				default: mask_nxt = mask_r;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				line_if_pkg::ADDR_RX_LEVEL: rdata_nxt = {4'h0, level_sync};
				line_if_pkg::ADDR_FAULT_STATUS: rdata_nxt = status_view;
				line_if_pkg::ADDR_FAULT_MASK: rdata_nxt = mask_r;
				line_if_pkg::ADDR_LINE_CTRL2: rdata_nxt = ctrl2_r;
				line_if_pkg::ADDR_LINE_CTRL3: rdata_nxt = ctrl3_r;
				line_if_pkg::ADDR_LINE_CTRL4: rdata_nxt = ctrl4_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
		// Set wins over the clear of a same-cycle read
		jnear_nxt = jitter_fifo_near_limit | (jnear_r & ~status_read);
		open_pend_nxt = (open_cond != open_prev_r) | (open_pend_r & ~status_read);
		climit_pend_nxt = (climit_cond != climit_prev_r) | (climit_pend_r & ~status_read);
		irq_nxt = (open_pend_r & mask_r[line_if_pkg::OPEN_FLAG_BIT])
			| (climit_pend_r & mask_r[line_if_pkg::CLIMIT_FLAG_BIT])
			| (jnear_r & mask_r[line_if_pkg::JNEAR_FLAG_BIT]);
		recovery_nxt = ctrl2_r[line_if_pkg::LINE_RESET_BIT] & ~reset_prev_r;
		rx_mark_nxt = rx_sync ^ ctrl3_r[line_if_pkg::CMI_INVERT_BIT];
		rx_term_nxt = term_decode(ctrl4_r[line_if_pkg::RX_TERM_LSB +: 3]);
		tx_term_nxt = term_decode(ctrl4_r[line_if_pkg::TX_TERM_LSB +: 3]);
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl2_r <= line_if_pkg::RESET_BYTE;
			ctrl3_r <= line_if_pkg::RESET_BYTE;
			ctrl4_r <= line_if_pkg::RESET_BYTE;
			mask_r <= line_if_pkg::RESET_BYTE;
			rdata_r <= line_if_pkg::RESET_BYTE;
			bpv_prev_r <= 1'b0;
			reset_prev_r <= 1'b0;
			recovery_r <= 1'b0;
			jnear_r <= 1'b0;
			open_pend_r <= 1'b0;
			climit_pend_r <= 1'b0;
			open_prev_r <= 1'b0;
			climit_prev_r <= 1'b0;
			irq_r <= 1'b0;
			rx_mark_r <= 1'b0;
			rx_term_r <= 4'h0;
			tx_term_r <= 4'h0;
		end else begin
			ctrl2_r <= ctrl2_nxt;
			ctrl3_r <= ctrl3_nxt;
			ctrl4_r <= ctrl4_nxt;
			mask_r <= mask_nxt;
			rdata_r <= rdata_nxt;
			bpv_prev_r <= ctrl2_r[line_if_pkg::INSERT_BPV_BIT];
			reset_prev_r <= ctrl2_r[line_if_pkg::LINE_RESET_BIT];
			recovery_r <= recovery_nxt;
			jnear_r <= jnear_nxt;
			open_pend_r <= open_pend_nxt;
			climit_pend_r <= climit_pend_nxt;
			open_prev_r <= open_cond;
			climit_prev_r <= climit_cond;
			irq_r <= irq_nxt;
			rx_mark_r <= rx_mark_nxt;
			rx_term_r <= rx_term_nxt;
			tx_term_r <= tx_term_nxt;
		end
	end

	// ==========================================
	// Transmit pattern and violation insertion
	line_if_pkg::bpv_state_e bpv_state_r, bpv_state_nxt;
	logic [1:0] run_r, run_nxt;
	logic pol_r, pol_nxt, alt_r, alt_nxt, pos_r, pos_nxt, neg_r, neg_nxt;
	logic src_bit, bpv_fire, bpv_arm, mark_pol, alt_en;

	assign alt_en = ctrl3_r[line_if_pkg::ALT_PATTERN_BIT];
	assign bpv_arm = ctrl2_r[line_if_pkg::INSERT_BPV_BIT] & ~bpv_prev_r;

	always_comb begin
		bpv_state_nxt = bpv_state_r;
		run_nxt = run_r;
		pol_nxt = pol_r;
		alt_nxt = alt_r;
		pos_nxt = pos_r;
		neg_nxt = neg_r;
		bpv_fire = 1'b0;
		mark_pol = pol_r;
		if (alt_en) begin
			src_bit = alt_r;
		end else if (!ctrl2_r[line_if_pkg::SEND_ALARM_BIT]) begin
			src_bit = 1'b1;
		end else begin
			src_bit = tx_bit;
		end
		if (tx_bit_valid) begin
			// Any one closing a run of three, so saturated all-ones traffic still qualifies
			bpv_fire = (bpv_state_r == line_if_pkg::BPV_ARMED) && src_bit
				&& (run_r >= line_if_pkg::ONES_BEFORE_BPV);
			alt_nxt = alt_en ? ~alt_r : 1'b1;
			if (!src_bit) begin
				run_nxt = 2'h0;
			end else if (run_r != line_if_pkg::ONES_RUN_MAX) begin
				run_nxt = run_r + 2'h1;
			end
			// A violation repeats the previous mark polarity
			mark_pol = bpv_fire ? ~pol_r : pol_r;
			if (src_bit && !bpv_fire) begin
				pol_nxt = ~pol_r;
			end
			pos_nxt = src_bit & (mark_pol ^ ctrl3_r[line_if_pkg::CMI_INVERT_BIT]);
			neg_nxt = src_bit & ~(mark_pol ^ ctrl3_r[line_if_pkg::CMI_INVERT_BIT]);
		end
		case (bpv_state_r)
			line_if_pkg::BPV_IDLE: if (bpv_arm) bpv_state_nxt = line_if_pkg::BPV_ARMED;
			line_if_pkg::BPV_ARMED: if (bpv_fire && !bpv_arm) bpv_state_nxt = line_if_pkg::BPV_IDLE;
			default: bpv_state_nxt = line_if_pkg::BPV_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			bpv_state_r <= line_if_pkg::BPV_IDLE;
			run_r <= 2'h0;
			pol_r <= 1'b1;
			alt_r <= 1'b1;
			pos_r <= 1'b0;
			neg_r <= 1'b0;
		end else begin
			bpv_state_r <= bpv_state_nxt;
			run_r <= run_nxt;
			pol_r <= pol_nxt;
			alt_r <= alt_nxt;
			pos_r <= pos_nxt;
			neg_r <= neg_nxt;
		end
	end

	// ==========================================
	// Outputs
	assign reg_rdata = rdata_r;
	assign tx_line_positive = pos_r;
	assign tx_line_negative = neg_r;
	assign rx_mark = rx_mark_r;
	assign recovery_reset = recovery_r;
	assign pll_12m8_enable = ctrl2_r[line_if_pkg::JCLK_HI_BIT];
	assign pll_2m048_enable = ctrl2_r[line_if_pkg::JCLK_LO_BIT];
	assign master_clock_prescale = ctrl4_r[line_if_pkg::PRESCALE_LSB +: 2];
	assign monitor_gain = ctrl3_r[line_if_pkg::GAIN_LSB +: 2];
	assign coded_mark_enable = ctrl3_r[line_if_pkg::CMI_ENABLE_BIT];
	assign rx_term_enable = rx_term_r;
	assign tx_term_enable = tx_term_r;
	assign interrupt_req = irq_r;

	// ==========================================
	// Assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	alarm_all_ones_a: assert property (tx_bit_valid && !alt_en && !ctrl2_r[line_if_pkg::SEND_ALARM_BIT]
		|=> tx_line_positive || tx_line_negative) else $error("alarm bit sent a space");
	bpv_arm_a: assert property ($rose(ctrl2_r[line_if_pkg::INSERT_BPV_BIT])
		|=> bpv_state_r == line_if_pkg::BPV_ARMED) else $error("violation not armed");
	bpv_single_a: assert property (bpv_fire && !bpv_arm |=> bpv_state_r == line_if_pkg::BPV_IDLE)
		else $error("violation request not retired");
	bpv_third_one_a: assert property (bpv_fire |-> src_bit && run_r >= line_if_pkg::ONES_BEFORE_BPV
		&& (pos_nxt == (~pol_r ^ ctrl3_r[line_if_pkg::CMI_INVERT_BIT])))
		else $error("violation at wrong place");
	reset_pulse_a: assert property ($rose(ctrl2_r[line_if_pkg::LINE_RESET_BIT])
		|=> recovery_reset ##1 !recovery_reset) else $error("line reset pulse wrong");
	pll_write_a: assert property (reg_wr && reg_addr == line_if_pkg::ADDR_LINE_CTRL2 |=> pll_12m8_enable ==
		$past(reg_wdata[7]) && pll_2m048_enable == $past(reg_wdata[3])) else $error("pll select stale");
	rx_term_map_a: assert property (ctrl4_r[2:0] == 3'h4 && $stable(ctrl4_r) |=> rx_term_enable == 4'h8)
		else $error("receive 110 ohm not selected");
	tx_term_off_a: assert property (ctrl4_r[5:3] > 3'h4 && $stable(ctrl4_r) |=> tx_term_enable == 4'h0)
		else $error("transmit termination not disabled");
	jnear_set_a: assert property (jitter_fifo_near_limit |=> jnear_r) else $error("jitter event lost");
	jnear_clear_a: assert property (status_read && !jitter_fifo_near_limit |=> !jnear_r)
		else $error("jitter event not cleared");
	fault_edge_a: assert property (mask_r[1] && $stable(mask_r) && open_cond != open_prev_r
		|=> ##1 interrupt_req) else $error("open edge gave no interrupt");
	irq_masked_a: assert property (mask_r == 8'h00 && $stable(mask_r) |=> !interrupt_req)
		else $error("interrupt with all masked");

	bpv_fired_c: cover property (bpv_fire);
	reset_seen_c: cover property (recovery_reset);
	irq_seen_c: cover property ($rose(interrupt_req));
	status_clear_c: cover property (status_read && jnear_r);
endmodule : line_interface_control_status

// file: testbench/line_partner.sv
// Far-side line model: receive pin, receive level pins and transmit fault pins.
// Assumes the bench commands the line state; outputs move only after a falling edge.
`timescale 1ns/1ps
module line_partner (
	input wire logic clock,
	input wire logic [3:0] level_cmd,
	input wire logic open_cmd,
	input wire logic climit_cmd,
	input wire logic rx_cmd,
	output logic rx_line_positive,
	output logic [3:0] rx_level_pin,
	output logic tx_open_pin,
	output logic tx_climit_pin
);
	initial begin
		rx_line_positive = 1'b0;
		rx_level_pin = 4'h0;
		tx_open_pin = 1'b0;
		tx_climit_pin = 1'b0;
	end
	// ==========================================
	// Line state
	always @(negedge clock) begin
		rx_line_positive <= rx_cmd;
		rx_level_pin <= level_cmd;
		tx_open_pin <= open_cmd;
		tx_climit_pin <= climit_cmd;
	end
endmodule : line_partner

// file: testbench/line_interface_control_status_tb.sv
// Self-checking bench for the line-interface control and status block.
// Assumes line_partner on the line side and a 100 MHz clock.
`timescale 1ns/1ps
module line_interface_control_status_tb;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic tx_bit_valid = 1'b0;
	logic tx_bit = 1'b0;
	logic jitter_fifo_near_limit = 1'b0;
	logic mode_6312k = 1'b0;
	logic mode_64k = 1'b0;
	logic [3:0] level_cmd = 4'h0;
	logic open_cmd = 1'b0;
	logic climit_cmd = 1'b0;
	logic rx_cmd = 1'b0;
	logic [7:0] reg_rdata;
	logic tx_line_positive, tx_line_negative, rx_line_positive, rx_mark;
	logic [3:0] rx_level_pin, rx_term_enable, tx_term_enable;
	logic tx_open_pin, tx_climit_pin, recovery_reset, pll_12m8_enable, pll_2m048_enable;
	logic [1:0] master_clock_prescale, monitor_gain;
	logic coded_mark_enable, interrupt_req;
	logic [7:0] rd_q[$];
	logic [1:0] tx_q[$];
	logic rd_seen = 1'b0;
	logic tx_seen = 1'b0;
	logic next_pos = 1'b1;
	logic swap = 1'b0;
	int fails = 0;
	int n_checks = 0;
	int cycles = 0;

	always #5 clock = ~clock;

	line_interface_control_status i_dut (.clock, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.tx_bit_valid, .tx_bit, .tx_line_positive, .tx_line_negative, .rx_line_positive, .rx_mark,
		.rx_level_pin, .tx_open_pin, .tx_climit_pin, .jitter_fifo_near_limit, .mode_6312k, .mode_64k,
		.recovery_reset, .pll_12m8_enable, .pll_2m048_enable, .master_clock_prescale, .monitor_gain,
		.coded_mark_enable, .rx_term_enable, .tx_term_enable, .interrupt_req);
	line_partner i_line (.clock, .level_cmd, .open_cmd, .climit_cmd, .rx_cmd, .rx_line_positive,
		.rx_level_pin, .tx_open_pin, .tx_climit_pin);

	// ==========================================
	// Compare, report and watcher
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_tx(input logic [1:0] got, input logic [1:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t line %b expected %b", $time, got, exp);
		end
	endtask : chk_tx
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	always @(posedge clock) begin
		rd_seen <= reg_rd;
		tx_seen <= tx_bit_valid;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end
	// Results were registered at the last rising edge, so they are settled here
	always @(negedge clock) begin
		if (rd_seen && rd_q.size() > 0) chk_val(reg_rdata, rd_q.pop_front());
		if (tx_seen && tx_q.size() > 0) chk_tx({tx_line_positive, tx_line_negative}, tx_q.pop_front());
	end

	// ==========================================
	// Drivers
	task automatic idle(input int n);
		repeat (n) @(negedge clock);
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		rd_q.push_back(e);
		@(negedge clock);
		reg_rd = 1'b0;
	endtask : rd
	// Violation keeps the last polarity, so the alternation is not advanced
	task automatic send(input logic b, input logic mark, input logic bipolar_violation);
		@(negedge clock);
		tx_bit = b;
		tx_bit_valid = 1'b1;
		if (!mark) tx_q.push_back(2'b00);
		else begin
			tx_q.push_back((next_pos ^ bipolar_violation ^ swap) ? 2'b10 : 2'b01);
			if (!bipolar_violation) next_pos = ~next_pos;
		end
		@(negedge clock);
		tx_bit_valid = 1'b0;
	endtask : send
	function automatic logic [3:0] term(input logic [2:0] c);
		return (c >= 3'h1 && c <= 3'h4) ? 4'h1 << (c - 3'h1) : 4'h0;
	endfunction : term

	// ==========================================
	// Scenarios
	initial begin
		logic [7:0] v;
		logic [7:0] adrs[7];
		logic [7:0] msk[7];
		logic [6:0] pat;
		int i;
		adrs = '{line_if_pkg::ADDR_LINE_CTRL2, line_if_pkg::ADDR_LINE_CTRL3, line_if_pkg::ADDR_LINE_CTRL4,
			line_if_pkg::ADDR_FAULT_MASK, line_if_pkg::ADDR_RX_LEVEL, line_if_pkg::ADDR_FAULT_STATUS, 8'h20};
		msk = '{8'hFB, 8'hD9, 8'hFF, 8'h16, 8'h00, 8'h00, 8'h00};
		pat = 7'b1110110;
		void'($urandom(32'h1ef6));
		idle(12);
		sys_rst = 1'b0;
		for (i = 0; i < 4; i++) send(1'($urandom), 1'b1, 1'b0);
		wr(adrs[0], 8'h10);
		v = 8'($urandom);
		for (i = 0; i < 8; i++) send(v[i], v[i], 1'b0);
		wr(adrs[1], 8'h40);
		swap = 1'b1;
		for (i = 0; i < 4; i++) send(1'b1, 1'b1, 1'b0);
		rx_cmd = 1'b1;
		idle(8);
		chk_val({7'h0, rx_mark}, 8'h00);
		wr(adrs[1], 8'h00);
		swap = 1'b0;
		idle(3);
		chk_val({7'h0, rx_mark}, 8'h01);
		wr(adrs[0], 8'h30);
		idle(2);
		for (i = 0; i < 7; i++) send(pat[i], pat[i], i == 6);
		// Held high without a fresh rising edge: no further violation
		wr(adrs[0], 8'h30);
		idle(2);
		for (i = 0; i < 3; i++) send(1'b1, 1'b1, 1'b0);
		wr(adrs[1], 8'h01);
		for (i = 0; i < 6; i++) begin
			@(negedge clock);
			tx_bit = 1'($urandom);
			tx_bit_valid = 1'b1;
			@(negedge clock);
			tx_bit_valid = 1'b0;
			v = {v[6:0], tx_line_positive | tx_line_negative};
			if (i > 0) chk_val({7'h0, v[0] ^ v[1]}, 8'h01);
		end
		wr(adrs[1], 8'h00);
		wr(adrs[0], 8'h50);
		chk_val({7'h0, recovery_reset}, 8'h00);
		idle(1);
		chk_val({7'h0, recovery_reset}, 8'h01);
		idle(1);
		chk_val({7'h0, recovery_reset}, 8'h00);
		wr(adrs[0], 8'h50);
		for (i = 0; i < 3; i++) begin
			idle(1);
			chk_val({7'h0, recovery_reset}, 8'h00);
		end
		wr(adrs[0], 8'h98);
		chk_val({6'h0, pll_12m8_enable, pll_2m048_enable}, 8'h03);
		wr(adrs[0], 8'h10);
		chk_val({6'h0, pll_12m8_enable, pll_2m048_enable}, 8'h00);
		wr(adrs[3], 8'h16);
		open_cmd = 1'b1;
		idle(8);
		chk_val({7'h0, interrupt_req}, 8'h01);
		rd(adrs[5], 8'h02);
		idle(2);
		chk_val({7'h0, interrupt_req}, 8'h00);
		open_cmd = 1'b0;
		idle(8);
		chk_val({7'h0, interrupt_req}, 8'h01);
		rd(adrs[5], 8'h00);
		idle(2);
		wr(adrs[3], 8'h00);
		open_cmd = 1'b1;
		mode_6312k = 1'b1;
		climit_cmd = 1'b1;
		idle(8);
		rd(adrs[5], 8'h00);
		mode_6312k = 1'b0;
		idle(2);
		rd(adrs[5], 8'h06);
		mode_64k = 1'b1;
		idle(2);
		rd(adrs[5], 8'h02);
		mode_64k = 1'b0;
		wr(adrs[1], 8'h80);
		idle(2);
		rd(adrs[5], 8'h02);
		chk_val({7'h0, interrupt_req}, 8'h00);
		open_cmd = 1'b0;
		climit_cmd = 1'b0;
		jitter_fifo_near_limit = 1'b1;
		idle(1);
		jitter_fifo_near_limit = 1'b0;
		idle(3);
		chk_val({7'h0, interrupt_req}, 8'h00);
		rd(adrs[5], 8'h10);
		rd(adrs[5], 8'h00);
		wr(adrs[3], 8'h10);
		jitter_fifo_near_limit = 1'b1;
		idle(1);
		jitter_fifo_near_limit = 1'b0;
		idle(3);
		chk_val({7'h0, interrupt_req}, 8'h01);
		rd(adrs[5], 8'h10);
		idle(2);
		chk_val({7'h0, interrupt_req}, 8'h00);
		for (i = 0; i < 4; i++) begin
			level_cmd = (i == 0) ? 4'hF : 4'($urandom);
			idle(8);
			rd(adrs[4], {4'h0, level_cmd});
		end
		level_cmd = 4'h0;
		idle(8);
		for (i = 0; i < 7; i++) begin
			wr(adrs[i], 8'hFF);
			rd(adrs[i], msk[i]);
		end
		for (i = 0; i < 8; i++) begin
			v = 8'($urandom);
			v[5:0] = {3'(7 - i), 3'(i)};
			wr(adrs[2], v);
			wr(adrs[1], {i[2], 2'h0, i[1:0], 3'h0});
			rd(adrs[2], v);
			chk_val({4'h0, rx_term_enable}, {4'h0, term(v[2:0])});
			chk_val({4'h0, tx_term_enable}, {4'h0, term(v[5:3])});
			chk_val({6'h0, master_clock_prescale}, {6'h0, v[7:6]});
			chk_val({6'h0, monitor_gain}, {6'h0, i[1:0]});
			chk_val({7'h0, coded_mark_enable}, {7'h0, i[2]});
		end
		@(negedge clock);
		sys_rst = 1'b1;
		idle(4);
		sys_rst = 1'b0;
		for (i = 0; i < 7; i++) rd(adrs[i], line_if_pkg::RESET_BYTE);
		chk_val({tx_line_positive, tx_line_negative, interrupt_req, pll_12m8_enable, tx_term_enable}, 8'h00);
		// Let the watcher take the last read before the run ends
		idle(1);
		finish_test();
	end
endmodule : line_interface_control_status_tb
